// ---- design/lcd_serial_host_control.sv ----
// module: serial host front end, command decoder and display timing
`timescale 1ns/1ps
module lcd_serial_host_control
    import lcdshc_pkg::*;
#(
    parameter logic CHIP_REVISION = 1'b0  // arbitrary value
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial link pins
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic commandDataSelect,
    input wire logic busTypeStrap,
    // loose configuration
    input wire logic columnWrap,
    input wire logic allPixelsOn,
    input wire logic pixelInverse,
    input wire logic suppliesReady,
    // display RAM write port
    output logic ramWrite,
    output logic [2:0] ramPage,
    output logic [6:0] ramColumn,
    output logic [7:0] ramData,
    // status and settings
    output logic [7:0] statusByte,
    output logic [2:0] frontIsolationClocks,
    output logic [2:0] endIsolationClocks,
    output logic [4:0] scanClockRatio,
    output logic [6:0] lineWidthClocks,
    output logic [5:0] lastRowDriver,
    output logic driversActiveFlag,
    output logic sleepState,
    // display drive
    output logic driversEnabled,
    output logic driversShorted,
    output logic pixelOnForce,
    output logic pixelInvert,
    output logic [5:0] scanLine,
    output logic [5:0] rowElectrode,
    output logic lineStrobe,
    output logic frameStrobe
);
    lcdshc_stream_if tokens();
    logic [2:0] csSync;
    logic [2:0] sckSync;
    logic [2:0] sdaSync;
    logic [2:0] cdSync;
    logic [2:0] bmSync;
    logic csN;
    logic sck;
    logic sckPrev;
    logic sckRise;
    logic sckFall;
    logic threeWire;
    logic [3:0] bitCount;
    logic [8:0] shiftReg;
    logic cdLatch;
    logic tokValid;
    logic [8:0] tokWord;
    logic tokReady;
    logic softReset;
    lcdshc_dec_t decState;
    logic [7:0] pendingCmd;
    logic [7:0] pendingSub;
    logic displayOnRequest;
    logic columnMirror;
    logic rowMirror;
    logic [6:0] columnIndex;
    logic [2:0] rowGroupIndex;
    lcdshc_pwr_t pwrState;
    logic [9:0] pwrCount;
    logic [5:0] divCount;
    logic scanTick;
    logic [6:0] lineCount;
    logic [5:0] dutyCount;
    logic cmdTaken;
    logic dataTaken;
    logic [7:0] tokByte;

    function automatic logic [6:0] mirror_col(input logic [6:0] col, input logic mx);
        mirror_col = mx ? (COL_LAST - col) : col;
    endfunction : mirror_col

    // pin synchronisers, three stages each
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            csSync <= 3'b111;
            sckSync <= 3'b111;
            sdaSync <= 3'b000;
            cdSync <= 3'b000;
            bmSync <= 3'b000;
        end
        else
        begin
            csSync <= {csSync[1:0], chipSelectN};
            sckSync <= {sckSync[1:0], serialClk};
            sdaSync <= {sdaSync[1:0], serialData};
            cdSync <= {cdSync[1:0], commandDataSelect};
            bmSync <= {bmSync[1:0], busTypeStrap};
        end
    end

    // filtered levels, updated when stages two and three agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            csN <= 1'b1;
            sck <= 1'b1;
            sckPrev <= 1'b1;
            threeWire <= 1'b0;
        end
        else
        begin
            if (csSync[1] == csSync[2])
                csN <= csSync[2];
            if (sckSync[1] == sckSync[2])
                sck <= sckSync[2];
            sckPrev <= sck;
            if (bmSync[1] == bmSync[2])
                threeWire <= bmSync[2];
        end
    end

    assign sckRise = sck && !sckPrev;
    assign sckFall = !sck && sckPrev;

    // serial shifter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bitCount <= 4'd0;
            shiftReg <= 9'h000;
            cdLatch <= 1'b0;
            tokValid <= 1'b0;
            tokWord <= 9'h000;
        end
        else
        begin
            if (tokValid && tokReady)
                tokValid <= 1'b0;
            if (csN || softReset)
                bitCount <= 4'd0;
            else
            begin
                // sample cd while clock low on last bit
                if (!threeWire && sck && sckFall == 1'b0 && bitCount == 4'd7)
                    cdLatch <= cdLatch;
                if (!threeWire && sckFall && bitCount == 4'd7)
                    cdLatch <= cdSync[2];
                if (sckRise)
                begin
                    shiftReg <= {shiftReg[7:0], sdaSync[2]};
                    if ((!threeWire && bitCount == 4'd7) || (threeWire && bitCount == 4'd8))
                    begin
                        bitCount <= 4'd0;
                        tokValid <= 1'b1;
                        tokWord <= threeWire ? {shiftReg[7:0], sdaSync[2]}
                                             : {cdLatch, shiftReg[6:0], sdaSync[2]};
                    end
                    else
                        bitCount <= bitCount + 4'd1;
                end
            end
        end
    end

    lcdshc_token_buf tokenBuf (
        .clk(clk),
        .nrst(nrst),
        .inValid(tokValid),
        .inToken(tokWord),
        .inReady(tokReady),
        .out(tokens.src)
    );

    // decoder drains one token per cycle unless a RAM write is pending
    assign tokens.ready = !ramWrite;
    assign tokByte = tokens.token[7:0];
    assign cmdTaken = tokens.valid && tokens.ready && !tokens.token[8];
    assign dataTaken = tokens.valid && tokens.ready && tokens.token[8];

    // command decoder and settings
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            decState <= LCDSHC_IDLE;
            pendingCmd <= 8'h00;
            pendingSub <= 8'h00;
            softReset <= 1'b0;
            frontIsolationClocks <= FRONT_ISO_RESET;
            endIsolationClocks <= END_ISO_RESET;
            scanClockRatio <= SCAN_RATIO_RESET;
            lineWidthClocks <= LINE_WIDTH_RESET;
            lastRowDriver <= ROW_END_RESET;
            displayOnRequest <= 1'b0;
            columnMirror <= 1'b0;
            rowMirror <= 1'b0;
        end
        else
        begin
            softReset <= 1'b0;
            if (csN)
                decState <= LCDSHC_IDLE;
            else if (cmdTaken)
            begin
                pendingCmd <= tokByte;
                decState <= LCDSHC_IDLE;
                case (tokByte)
                    CMD_WRITE_DATA: decState <= LCDSHC_DATA;
                    CMD_TRIPLE: decState <= LCDSHC_SUB;
                    CMD_STATUS, CMD_COLUMN, CMD_ENABLE, CMD_SYSRESET,
                    CMD_ROWEND, CMD_CLOCK: decState <= LCDSHC_PARAM;
                    default:
                    begin
                        if (tokByte[7:4] == CMD_LCTRL_HI)
                        begin
                            rowMirror <= tokByte[3];
                            columnMirror <= tokByte[2];
                        end
                    end
                endcase
            end
            else if (dataTaken)
            begin
                case (decState)
                    LCDSHC_PARAM:
                    begin
                        decState <= LCDSHC_IDLE;
                        case (pendingCmd)
                            CMD_ENABLE: displayOnRequest <= tokByte[0];
                            CMD_CLOCK: scanClockRatio <= tokByte[4:0];
                            CMD_ROWEND: lastRowDriver <= tokByte[5:0];
                            CMD_SYSRESET: softReset <= 1'b1;
                            default: decState <= LCDSHC_IDLE;
                        endcase
                    end
                    LCDSHC_SUB:
                    begin
                        pendingSub <= tokByte;
                        decState <= LCDSHC_VALUE;
                    end
                    LCDSHC_VALUE:
                    begin
                        decState <= LCDSHC_IDLE;
                        case (pendingSub)
                            SUB_WIDTH: lineWidthClocks <= tokByte[6:0];
                            SUB_FRONT: frontIsolationClocks <= tokByte[2:0];
                            SUB_END: endIsolationClocks <= tokByte[2:0];
                            default: decState <= LCDSHC_IDLE;
                        endcase
                    end
                    LCDSHC_DATA: decState <= LCDSHC_DATA;
                    default: decState <= LCDSHC_IDLE;
                endcase
            end
        end
    end

    // RAM address pointers and write port
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            columnIndex <= 7'd0;
            rowGroupIndex <= 3'd0;
            ramWrite <= 1'b0;
            ramPage <= 3'd0;
            ramColumn <= 7'd0;
            ramData <= 8'h00;
        end
        else
        begin
            ramWrite <= 1'b0;
            if (softReset)
            begin
                columnIndex <= 7'd0;
                rowGroupIndex <= 3'd0;
            end
            else if (cmdTaken && tokByte[7:3] == CMD_PAGE_HI)
                rowGroupIndex <= tokByte[2:0];
            else if (dataTaken && decState == LCDSHC_PARAM && pendingCmd == CMD_COLUMN)
                columnIndex <= tokByte[6:0];
            else if (dataTaken && (decState == LCDSHC_DATA || decState == LCDSHC_IDLE))
            begin
                ramWrite <= 1'b1;
                ramPage <= rowGroupIndex;
                ramColumn <= mirror_col(columnIndex, columnMirror);
                ramData <= tokByte;
                if (columnIndex != COL_LAST)
                    columnIndex <= columnIndex + 7'd1;
                else if (columnWrap)
                begin
                    columnIndex <= 7'd0;
                    rowGroupIndex <= (rowGroupIndex == PAGE_LAST) ? 3'd0 : rowGroupIndex + 3'd1;
                end
            end
        end
    end

    // power sequencing
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwrState <= LCDSHC_SLEEP;
            pwrCount <= 10'd0;
        end
        else
        begin
            case (pwrState)
                LCDSHC_SLEEP:
                begin
                    pwrCount <= 10'd0;
                    if (displayOnRequest)
                        pwrState <= LCDSHC_POWER;
                end
                LCDSHC_POWER:
                begin
                    if (!displayOnRequest)
                        pwrState <= LCDSHC_SLEEP;
                    else if (pwrCount >= POWER_UP_COUNT && suppliesReady)
                        pwrState <= LCDSHC_ACTIVE;
                    else if (pwrCount < POWER_UP_COUNT)
                        pwrCount <= pwrCount + 10'd1;
                end
                LCDSHC_ACTIVE:
                begin
                    if (!displayOnRequest)
                        pwrState <= LCDSHC_SLEEP;
                end
                default: pwrState <= LCDSHC_SLEEP;
            endcase
        end
    end

    // scan clock, line and frame timing
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            divCount <= 6'd0;
            scanTick <= 1'b0;
            lineCount <= 7'd0;
            dutyCount <= 6'd0;
            scanLine <= 6'd0;
            lineStrobe <= 1'b0;
            frameStrobe <= 1'b0;
        end
        else
        begin
            lineStrobe <= 1'b0;
            frameStrobe <= 1'b0;
            scanTick <= 1'b0;
            if (scanClockRatio == 5'd0 || divCount >= {scanClockRatio, 1'b0} - 6'd1)
            begin
                divCount <= 6'd0;
                scanTick <= 1'b1;
            end
            else
                divCount <= divCount + 6'd1;
            if (scanTick)
            begin
                if (lineCount + 7'd1 >= lineWidthClocks)
                begin
                    lineCount <= 7'd0;
                    lineStrobe <= 1'b1;
                    scanLine <= (scanLine == LINE_LAST) ? 6'd0 : scanLine + 6'd1;
                    if (dutyCount >= lastRowDriver)
                    begin
                        dutyCount <= 6'd0;
                        frameStrobe <= 1'b1;
                    end
                    else
                        dutyCount <= dutyCount + 6'd1;
                end
                else
                    lineCount <= lineCount + 7'd1;
            end
        end
    end

    // drive outputs and status
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            driversActiveFlag <= 1'b0;
            sleepState <= 1'b1;
            driversEnabled <= 1'b0;
            driversShorted <= 1'b1;
            pixelOnForce <= 1'b0;
            pixelInvert <= 1'b0;
            rowElectrode <= 6'd0;
            statusByte <= 8'h00;
        end
        else
        begin
            driversActiveFlag <= displayOnRequest;
            sleepState <= (pwrState == LCDSHC_SLEEP);
            driversEnabled <= (pwrState == LCDSHC_ACTIVE);
            driversShorted <= (pwrState != LCDSHC_ACTIVE);
            pixelOnForce <= (pwrState == LCDSHC_ACTIVE) && allPixelsOn;
            pixelInvert <= (pwrState == LCDSHC_ACTIVE) && pixelInverse;
            rowElectrode <= rowMirror ? (LINE_LAST - scanLine) : scanLine;
            statusByte <= {CHIP_REVISION, displayOnRequest, columnMirror, rowMirror, 4'h0};
        end
    end
endmodule : lcd_serial_host_control

// ---- design/lcdshc_pkg.sv ----
// package: constants and types for the serial display controller front end
package lcdshc_pkg;
    localparam logic [7:0] CMD_WRITE_DATA = 8'h01;
    localparam logic [7:0] CMD_STATUS = 8'h03;
    localparam logic [7:0] CMD_COLUMN = 8'h04;
    localparam logic [4:0] CMD_PAGE_HI = 5'h16;
    localparam logic [3:0] CMD_LCTRL_HI = 4'hA;
    localparam logic [7:0] CMD_ENABLE = 8'hC9;
    localparam logic [7:0] CMD_SYSRESET = 8'hE1;
    localparam logic [7:0] CMD_ROWEND = 8'hF1;
    localparam logic [7:0] CMD_TRIPLE = 8'h82;
    localparam logic [7:0] CMD_CLOCK = 8'h83;
    localparam logic [7:0] SUB_WIDTH = 8'h00;
    localparam logic [7:0] SUB_FRONT = 8'h01;
    localparam logic [7:0] SUB_END = 8'h02;
    localparam logic [2:0] FRONT_ISO_RESET = 3'h1;
    localparam logic [2:0] END_ISO_RESET = 3'h0;
    localparam logic [4:0] SCAN_RATIO_RESET = 5'h06;
    localparam logic [6:0] LINE_WIDTH_RESET = 7'h16;
    localparam logic [5:0] ROW_END_RESET = 6'h3F;
    localparam logic [6:0] COL_LAST = 7'h7F;
    localparam logic [2:0] PAGE_LAST = 3'h7;
    localparam logic [5:0] LINE_LAST = 6'h3F;
    localparam int POWER_UP_US = 10;
    localparam int CLK_MHZ = 50;
    localparam int POWER_UP_CYCLES = POWER_UP_US * CLK_MHZ;
    localparam logic [9:0] POWER_UP_COUNT = 10'(POWER_UP_CYCLES);
    typedef enum logic [2:0] {
        LCDSHC_IDLE = 3'b000,
        LCDSHC_PARAM = 3'b001,
        LCDSHC_SUB = 3'b010,
        LCDSHC_VALUE = 3'b011,
        LCDSHC_DATA = 3'b100
    } lcdshc_dec_t;
    typedef enum logic [1:0] {
        LCDSHC_SLEEP = 2'b00,
        LCDSHC_POWER = 2'b01,
        LCDSHC_ACTIVE = 2'b10
    } lcdshc_pwr_t;
endpackage : lcdshc_pkg

// ---- design/lcdshc_stream_if.sv ----
// interface: received serial token stream between shifter buffer and decoder
`timescale 1ns/1ps
interface lcdshc_stream_if;
    logic valid;
    logic ready;
    logic [8:0] token;
    modport src (output valid, output token, input ready);
    modport snk (input valid, input token, output ready);
endinterface : lcdshc_stream_if

// ---- design/lcdshc_token_buf.sv ----
// module: two-entry token buffer with valid/ready on both sides
`timescale 1ns/1ps
module lcdshc_token_buf
    import lcdshc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // filling side
    input wire logic inValid,
    input wire logic [8:0] inToken,
    output logic inReady,
    // draining side
    lcdshc_stream_if.src out
);
    logic [8:0] slot [2];
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic doWrite;
    logic doRead;

    assign inReady = (count != 2'd2);
    assign doWrite = inValid && inReady;
    assign doRead = out.valid && out.ready;
    assign out.valid = (count != 2'd0);
    assign out.token = slot[rdPtr];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'd0;
            slot[0] <= 9'h000;
            slot[1] <= 9'h000;
        end
        else
        begin
            if (doWrite)
            begin
                slot[wrPtr] <= inToken;
                wrPtr <= ~wrPtr;
            end
            if (doRead)
            begin
                rdPtr <= ~rdPtr;
            end
            count <= count + 2'(doWrite) - 2'(doRead);
        end
    end
endmodule : lcdshc_token_buf

// ---- verification/lcdshc_monitor.sv ----
// checker bound to the serial display controller top module
`timescale 1ns/1ps
module lcdshc_monitor #(
    parameter logic CHIP_REVISION = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // drive state
    input wire logic driversEnabled,
    input wire logic driversShorted,
    input wire logic driversActiveFlag,
    input wire logic sleepState,
    input wire logic pixelOnForce,
    input wire logic pixelInvert,
    // status and scan
    input wire logic [7:0] statusByte,
    input wire logic lineStrobe,
    input wire logic [5:0] scanLine,
    input wire logic [5:0] rowElectrode,
    input wire logic [4:0] scanClockRatio,
    input wire logic [6:0] lineWidthClocks,
    // frame timing
    input wire logic frameStrobe,
    input wire logic [5:0] lastRowDriver
);
    logic [15:0] gap;
    logic [15:0] period;
    logic [1:0] seen;
    logic [5:0] lines;
    logic fseen;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    assign period = (scanClockRatio == 5'h00 ? 16'h0001 : {10'h000, scanClockRatio, 1'b0})
        * {9'h000, lineWidthClocks};
    // cycles since the last line strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            gap <= '0;
        else
            gap <= lineStrobe ? '0 : gap + 16'h0001;
    end
    // two whole lines after any timing change
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            seen <= '0;
        else if ($changed(scanClockRatio) || $changed(lineWidthClocks))
            seen <= '0;
        else if (lineStrobe && seen != 2'h2)
            seen <= seen + 2'h1;
    end
    property p_idle_short;
        $stable(driversEnabled) |-> driversShorted == !driversEnabled;
    endproperty
    a_idle_short: assert property (p_idle_short) else $error("idle short wrong");
    property p_sleep;
        $fell(driversActiveFlag) |-> ##[0:4] (!driversEnabled && sleepState);
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep after off");
    property p_wake;
        $rose(driversActiveFlag) |-> !driversEnabled [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("drivers on before power up");
    property p_override;
        !driversActiveFlag && !$past(driversActiveFlag) |-> !pixelOnForce && !pixelInvert;
    endproperty
    a_override: assert property (p_override) else $error("pixel setting while off");
    property p_mirror;
        $stable(scanLine) && $stable(statusByte[4])
            |-> rowElectrode == (statusByte[4] ? 6'h3F - scanLine : scanLine);
    endproperty
    a_mirror: assert property (p_mirror) else $error("row mapping wrong");
    property p_line_step;
        $changed(scanLine) |-> scanLine == $past(scanLine) + 6'h01;
    endproperty
    a_line_step: assert property (p_line_step) else $error("scan line step wrong");
    property p_line_gap;
        lineStrobe && seen == 2'h2 |-> gap == period - 16'h0001;
    endproperty
    a_line_gap: assert property (p_line_gap) else $error("line period wrong");
    // lines since the last frame strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lines <= '0;
        else if (lineStrobe)
            lines <= frameStrobe ? 6'h00 : lines + 6'h01;
    end
    // one whole frame after any duty change
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fseen <= 1'b0;
        else if ($changed(lastRowDriver))
            fseen <= 1'b0;
        else if (frameStrobe)
            fseen <= 1'b1;
    end
    property p_frame;
        frameStrobe && fseen |-> lines == lastRowDriver;
    endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");
    property p_status;
        statusByte[3:0] == 4'h0 && statusByte[7] == CHIP_REVISION;
    endproperty
    a_status: assert property (p_status) else $error("status low bits wrong");
endmodule : lcdshc_monitor
bind lcd_serial_host_control lcdshc_monitor #(.CHIP_REVISION(CHIP_REVISION)) u_lcdshc_monitor (
    .clk(clk), .nrst(nrst), .driversEnabled(driversEnabled), .driversShorted(driversShorted),
    .driversActiveFlag(driversActiveFlag), .sleepState(sleepState),
    .pixelOnForce(pixelOnForce), .pixelInvert(pixelInvert), .statusByte(statusByte),
    .lineStrobe(lineStrobe), .scanLine(scanLine), .rowElectrode(rowElectrode),
    .scanClockRatio(scanClockRatio), .lineWidthClocks(lineWidthClocks),
    .frameStrobe(frameStrobe), .lastRowDriver(lastRowDriver)
);

// ---- verification/lcdshc_host_model.sv ----
// host serial master model for the four- and three-wire links
`timescale 1ns/1ps
module lcdshc_host_model (
    // clock and mode
    input wire logic clk,
    input wire logic threeWire,
    // link pins
    output logic chipSelectN,
    output logic serialClk,
    output logic serialData,
    output logic commandDataSelect
);
    initial
    begin
        chipSelectN = 1'b1;
        serialClk = 1'b1;
        serialData = 1'b0;
        commandDataSelect = 1'b0;
    end
    task automatic half;
        repeat (5) @(negedge clk);
    endtask : half
    task automatic bit_out(input logic b);
        serialClk = 1'b0;
        serialData = b;
        half();
        serialClk = 1'b1;
        half();
    endtask : bit_out
    task automatic send(input logic cd, input logic [7:0] b, input int n);
        chipSelectN = 1'b0;
        half();
        if (threeWire)
            bit_out(cd);
        for (int i = 0; i < n; i++)
        begin
            // valid at last bit, tied in three-wire
            commandDataSelect = threeWire ? 1'b0 : (i == 7 ? cd : !cd);
            bit_out(b[7 - i]);
        end
    endtask : send
    task automatic release_cs;
        chipSelectN = 1'b1;
        serialData = !serialData;
        half();
        half();
    endtask : release_cs
endmodule : lcdshc_host_model

// ---- verification/tb.sv ----
// testbench for the serial display controller front end
`timescale 1ns/1ps
module tb
    import lcdshc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic busTypeStrap = 1'b0;
    logic columnWrap = 1'b0;
    logic allPixelsOn = 1'b0;
    logic pixelInverse = 1'b0;
    logic suppliesReady = 1'b0;
    logic chipSelectN, serialClk, serialData, commandDataSelect, ramWrite, driversActiveFlag;
    logic sleepState, driversEnabled, driversShorted, pixelOnForce, pixelInvert;
    logic [2:0] ramPage, frontIsolationClocks, endIsolationClocks, wrPage;
    logic [6:0] ramColumn, wrCol, lineWidthClocks;
    logic [5:0] lastRowDriver;
    logic [7:0] ramData, statusByte, wrData;
    logic [4:0] scanClockRatio;
    int errTotal = 0;
    int numChecks = 0;
    always #10 clk = ~clk;
    lcdshc_host_model u_lcdshc_host_model (
        .clk(clk), .threeWire(busTypeStrap), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialData(serialData), .commandDataSelect(commandDataSelect)
    );
    lcd_serial_host_control u_lcd_serial_host_control (
        .clk(clk), .nrst(nrst), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialData(serialData), .commandDataSelect(commandDataSelect),
        .busTypeStrap(busTypeStrap), .columnWrap(columnWrap), .allPixelsOn(allPixelsOn),
        .pixelInverse(pixelInverse), .suppliesReady(suppliesReady), .ramWrite(ramWrite),
        .ramPage(ramPage), .ramColumn(ramColumn), .ramData(ramData), .statusByte(statusByte),
        .frontIsolationClocks(frontIsolationClocks), .endIsolationClocks(endIsolationClocks),
        .scanClockRatio(scanClockRatio), .lineWidthClocks(lineWidthClocks),
        .lastRowDriver(lastRowDriver),
        .driversActiveFlag(driversActiveFlag), .sleepState(sleepState),
        .driversEnabled(driversEnabled), .driversShorted(driversShorted),
        .pixelOnForce(pixelOnForce), .pixelInvert(pixelInvert), .scanLine(), .rowElectrode(),
        .lineStrobe(), .frameStrobe()
    );
    // last RAM write seen
    always @(posedge clk)
    begin
        if (ramWrite === 1'b1)
        begin
            wrCol <= ramColumn;
            wrPage <= ramPage;
            wrData <= ramData;
        end
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tx(input logic cd, input logic [7:0] b);
        u_lcdshc_host_model.send(cd, b, 8);
        w(8);
    endtask : tx
    task automatic tx2(input logic [7:0] a, input logic [7:0] b);
        tx(1'b0, a);
        tx(1'b1, b);
    endtask : tx2
    task automatic tx3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        tx2(a, b);
        tx(1'b1, c);
    endtask : tx3
    task automatic closeOut;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : closeOut
    initial
    begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        w(5);
        chk(8'(frontIsolationClocks), 8'h01);
        chk(8'(endIsolationClocks), 8'h00);
        chk(8'(scanClockRatio), 8'h06);
        chk({statusByte[7:1], sleepState}, 8'h01);
        $display("defaults test done");
        tx3(8'h82, 8'h01, 8'h05);
        chk(8'(frontIsolationClocks), 8'h05);
        tx3(8'h82, 8'h02, 8'h03);
        chk(8'(endIsolationClocks), 8'h03);
        tx2(8'h83, 8'h01);
        chk(8'(scanClockRatio), 8'h01);
        tx2(8'h82, 8'h01);
        u_lcdshc_host_model.release_cs();
        tx(1'b1, 8'h07);
        chk({wrData[6:0], frontIsolationClocks[0]}, 8'h0F);
        u_lcdshc_host_model.send(1'b0, 8'hFF, 4);
        u_lcdshc_host_model.release_cs();
        tx3(8'h82, 8'h01, 8'h06);
        chk(8'(frontIsolationClocks), 8'h06);
        tx3(8'h82, 8'h00, 8'h30);
        chk(8'(lineWidthClocks), 8'h30);
        tx2(8'hF1, 8'h07);
        chk(8'(lastRowDriver), 8'h07);
        $display("settings test done");
        tx2(8'h04, 8'h7E);
        for (int i = 0; i < 3; i++)
        begin
            tx(1'b1, 8'hA0 + 8'(i));
            chk(wrData, 8'hA0 + 8'(i));
            chk(8'(wrCol), i == 0 ? 8'h7E : 8'h7F);
        end
        columnWrap = 1'b1;
        tx(1'b1, 8'hC1);
        tx(1'b1, 8'hC2);
        chk({wrPage, 1'b0, wrCol[3:0]}, 8'h20);
        tx(1'b0, 8'hA4);
        tx2(8'h04, 8'h05);
        tx(1'b1, 8'h33);
        chk(8'(wrCol), 8'h7A);
        chk(statusByte, 8'h20);
        tx(1'b0, 8'hA8);
        chk(statusByte, 8'h10);
        tx2(8'hE1, 8'hE2);
        tx2(8'h01, 8'h66);
        chk(wrData, 8'h66);
        chk({wrPage, 1'b0, wrCol[3:0]}, 8'h00);
        w(300);
        $display("ram test done");
        busTypeStrap = 1'b1;
        tx(1'b1, 8'h5A);
        chk(wrData, 8'h5A);
        tx2(8'h83, 8'h00);
        chk(8'(scanClockRatio), 8'h00);
        $display("three-wire test done");
        allPixelsOn = 1'b1;
        pixelInverse = 1'b1;
        suppliesReady = 1'b1;
        tx2(8'hC9, 8'hAF);
        chk({6'h00, driversActiveFlag, driversEnabled}, 8'h02);
        w(POWER_UP_CYCLES + 20);
        chk({6'h00, driversEnabled, driversShorted}, 8'h02);
        chk({6'h00, pixelOnForce, pixelInvert}, 8'h03);
        tx2(8'hC9, 8'hAE);
        chk({6'h00, driversEnabled, driversShorted}, 8'h01);
        chk({6'h00, sleepState, pixelOnForce}, 8'h02);
        $display("power test done");
        w(1500);
        closeOut();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errTotal++;
        closeOut();
    end
endmodule : tb
